/* File: src/sap_device.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
module sap_device
  import sap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins toward the host
  sap_if.device pins,
  // analog side: held level to be converted, same clock domain
  input wire logic [`SAP_RESULT_W-1:0] analog_level,
  // user side status
  output logic [`SAP_RESULT_W-1:0] result_word,
  output logic result_strobe,
  output logic converting
);

  // ==========================================================
  // pin input filtering
  // ==========================================================
  logic [3:0] pin_raw;
  logic [3:0] s1_q, s1_d;
  logic [3:0] s2_q, s2_d;
  logic [3:0] s3_q, s3_d;
  logic [3:0] filt_q, filt_d;

  assign pin_raw = {pins.cs_n, pins.rd_n, pins.high_byte_select,
                    pins.clk_in};

  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    s3_d = s2_q;
    filt_d = sap_agree4(filt_q, s2_q, s3_q);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= `SAP_PIN_IDLE;
      s2_q <= `SAP_PIN_IDLE;
      s3_q <= `SAP_PIN_IDLE;
      filt_q <= `SAP_PIN_IDLE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
    end
  end

  // ==========================================================
  // decoded pin levels
  // ==========================================================
  logic sel;
  logic strobe;
  logic high_byte;
  logic clk_level;
  logic start_cond;
  logic read_en;

  always_comb begin
    // chip select high masks strobe and byte select entirely
    sel = ~filt_q[`SAP_PIN_CS];
    strobe = sel & ~filt_q[`SAP_PIN_RD];
    high_byte = sel & filt_q[`SAP_PIN_HB];
    clk_level = filt_q[`SAP_PIN_CK];
    start_cond = strobe & ~high_byte;
    read_en = strobe;
  end

  // ==========================================================
  // conversion sequencer
  // ==========================================================
  sap_dev_state_t state_q, state_d;
  logic [`SAP_RESULT_W-1:0] hold_q, hold_d;
  logic [`SAP_RESULT_W-1:0] sar_q, sar_d;
  logic [`SAP_RESULT_W-1:0] latch_q, latch_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] fall_q, fall_d;
  logic busy_n_q, busy_n_d;
  logic done_q, done_d;
  logic start_prev_q, start_prev_d;
  logic clk_prev_q, clk_prev_d;
  logic start_edge;
  logic clk_fall;
  logic [`SAP_RESULT_W-1:0] trial;
  logic [`SAP_RESULT_W-1:0] decided;

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    sar_d = sar_q;
    latch_d = latch_q;
    bit_d = bit_q;
    fall_d = fall_q;
    busy_n_d = busy_n_q;
    done_d = 1'b0;
    start_prev_d = start_cond;
    clk_prev_d = clk_level;
    // a start is the entry into the start condition, so a held strobe
    // cannot retrigger once the conversion ends
    start_edge = start_cond & ~start_prev_q;
    clk_fall = clk_prev_q & ~clk_level;
    trial = sar_q | (`SAP_RESULT_W'(1) << bit_q);
    decided = (trial <= hold_q) ? trial : sar_q;
    case (state_q)
      SAP_DEV_IDLE: begin
        if (start_edge) begin
          state_d = SAP_DEV_CONVERT;
          hold_d = analog_level;
          sar_d = '0;
          bit_d = `SAP_MSB_INDEX;
          fall_d = 4'h0;
          busy_n_d = 1'b0;
        end
      end
      SAP_DEV_CONVERT: begin
        // further starts are not looked at until the end
        if (clk_fall) begin
          if (fall_q < `SAP_FIRST_DECISION_FALL - 4'h1) begin
            fall_d = fall_q + 4'h1;
          end else begin
            sar_d = decided;
            bit_d = bit_q - 4'h1;
            if (bit_q == 4'h0) begin
              // twelve decisions after the second fall: 12 to 13 periods
              state_d = SAP_DEV_IDLE;
              latch_d = decided;
              busy_n_d = 1'b1;
              done_d = 1'b1;
            end
          end
        end
      end
      default: begin
        state_d = SAP_DEV_IDLE;
        busy_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= SAP_DEV_IDLE;
      hold_q <= '0;
      sar_q <= '0;
      latch_q <= '0;
      bit_q <= `SAP_MSB_INDEX;
      fall_q <= 4'h0;
      busy_n_q <= 1'b1;
      done_q <= 1'b0;
      start_prev_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      sar_q <= sar_d;
      latch_q <= latch_d;
      bit_q <= bit_d;
      fall_q <= fall_d;
      busy_n_q <= busy_n_d;
      done_q <= done_d;
      start_prev_q <= start_prev_d;
      clk_prev_q <= clk_prev_d;
    end
  end

  // ==========================================================
  // pin drivers
  // ==========================================================
  logic [7:0] upper_q, upper_d;
  logic [3:0] low_q, low_d;
  logic oe_q, oe_d;
  logic clk_out_q, clk_out_d;
  logic conv_q, conv_d;

  always_comb begin
    // reads only ever look at the latch, never disturb it
    upper_d = latch_q[11:4];
    low_d = latch_q[3:0];
    if (high_byte) begin
      upper_d = {latch_q[11:8], 4'h0};
      low_d = latch_q[11:8];
    end
    oe_d = read_en;
    // in step with the filtered input, not a cycle behind it; only a flop may drive a pin
    clk_out_d = ~filt_d[`SAP_PIN_CK];
    // user status mirrors busy from a flop of its own
    conv_d = ~busy_n_d;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      upper_q <= 8'h00;
      low_q <= 4'h0;
      oe_q <= 1'b0;
      clk_out_q <= 1'b1;
      conv_q <= 1'b0;
    end else begin
      upper_q <= upper_d;
      low_q <= low_d;
      oe_q <= oe_d;
      clk_out_q <= clk_out_d;
      conv_q <= conv_d;
    end
  end

  assign pins.upper_data_pins = upper_q;
  assign pins.shared_low_data_pins = low_q;
  assign pins.data_oe = oe_q;
  assign pins.clk_out = clk_out_q;
  assign pins.conv_busy_n = busy_n_q;
  assign result_word = latch_q;
  assign result_strobe = done_q;
  assign converting = conv_q;

endmodule : sap_device
`default_nettype wire

/* File: shared/sap_regs.svh */
// Functional notes
// - low strobe, select, low byte starts conversion
// - high byte select blocks conversion start
// - data drivers on only with strobe+select low
// - chip select high ignores strobe and byte
// - busy output low throughout each conversion
// - low byte select: full word, msb on top
// - high byte: top nibble twice, middle low
// - conversion lasts 12 to 13 clock periods
// - host waits 1 us between conversions
// - host keeps strobe high 200 ns between reads
// - host holds byte select across strobe low
// - new data valid shortly after busy rises
// - clock output is inverted clock input
// - host starts 40 ns away from clock edges
// - start clears register; no restart mid conversion
// - first decision on second falling clock edge
// - finished result loads into output latch
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH

`define SAP_RESULT_W 12
`define SAP_CLK_PERIOD_NS 4
// pin vector bit positions: chip select, strobe, byte select, clock
`define SAP_PIN_CS 3
`define SAP_PIN_RD 2
`define SAP_PIN_HB 1
`define SAP_PIN_CK 0
`define SAP_PIN_IDLE 4'hC
`define SAP_FIRST_DECISION_FALL 4'h2
`define SAP_MSB_INDEX 4'hB
`define SAP_ACQ_NS 1000
`define SAP_ACQ_CYC ((`SAP_ACQ_NS + `SAP_CLK_PERIOD_NS - 1) / `SAP_CLK_PERIOD_NS)
`define SAP_RD_GAP_NS 200
`define SAP_RD_GAP_CYC \
  ((`SAP_RD_GAP_NS + `SAP_CLK_PERIOD_NS - 1) / `SAP_CLK_PERIOD_NS)
`define SAP_GUARD_NS 40
`define SAP_GUARD_CYC \
  ((`SAP_GUARD_NS + `SAP_CLK_PERIOD_NS - 1) / `SAP_CLK_PERIOD_NS)
`define SAP_ACCESS_NS 90
`define SAP_ACCESS_CYC \
  ((`SAP_ACCESS_NS + `SAP_CLK_PERIOD_NS - 1) / `SAP_CLK_PERIOD_NS)
`define SAP_SYNC_MARGIN_CYC 8
`define SAP_RD_PULSE_CYC (`SAP_ACCESS_CYC + `SAP_SYNC_MARGIN_CYC)
`define SAP_CONV_CLK_DIV 64

`endif

/* File: shared/sap_pkg.sv */
package sap_pkg;

  typedef enum logic {
    SAP_DEV_IDLE,
    SAP_DEV_CONVERT
  } sap_dev_state_t;

  typedef enum logic [1:0] {
    SAP_HOST_IDLE,
    SAP_HOST_ALIGN,
    SAP_HOST_STROBE
  } sap_host_state_t;

  // three-stage pin filter: a bit moves only when stages two and three agree
  function automatic logic [3:0] sap_agree4(input logic [3:0] held,
                                            input logic [3:0] s2,
                                            input logic [3:0] s3);
    sap_agree4 = (s2 & s3) | (held & (s2 ^ s3));
  endfunction : sap_agree4

  function automatic logic [11:0] sap_agree12(input logic [11:0] held,
                                              input logic [11:0] s2,
                                              input logic [11:0] s3);
    sap_agree12 = (s2 & s3) | (held & (s2 ^ s3));
  endfunction : sap_agree12

endpackage : sap_pkg

/* File: shared/sap_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sap_if;
  // host driven pins
  logic cs_n;
  logic rd_n;
  logic high_byte_select;
  logic clk_in;
  // device driven pins
  logic clk_out;
  logic conv_busy_n;
  logic [7:0] upper_data_pins;
  logic [3:0] shared_low_data_pins;
  logic data_oe;

  modport device (
    input cs_n,
    input rd_n,
    input high_byte_select,
    input clk_in,
    output clk_out,
    output conv_busy_n,
    output upper_data_pins,
    output shared_low_data_pins,
    output data_oe
  );

  modport host (
    output cs_n,
    output rd_n,
    output high_byte_select,
    output clk_in,
    input clk_out,
    input conv_busy_n,
    input upper_data_pins,
    input shared_low_data_pins,
    input data_oe
  );
endinterface : sap_if
`default_nettype wire

/* File: src/sap_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
module sap_host
  import sap_pkg::*;
#(
  parameter int CLK_DIV = `SAP_CONV_CLK_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pins toward the converter
  sap_if.host pins,
  // command side: high selects a byte read, low a word read plus start
  input wire logic cmd_valid,
  input wire logic cmd_high,
  output logic cmd_ready,
  // answer side
  output logic rsp_valid,
  output logic [`SAP_RESULT_W-1:0] rsp_data,
  output logic adc_busy
);

  localparam int HALF = CLK_DIV / 2;
  localparam logic [15:0] HALF_M1 = 16'(HALF - 1);
  localparam logic [15:0] WIN_LO = 16'(`SAP_GUARD_CYC);
  localparam logic [15:0] WIN_HI = 16'(HALF - `SAP_GUARD_CYC);
  localparam logic [15:0] ACQ_MAX = 16'(`SAP_ACQ_CYC);
  localparam logic [15:0] GAP_MAX = 16'(`SAP_RD_GAP_CYC);
  localparam logic [15:0] PULSE_MAX = 16'(`SAP_RD_PULSE_CYC);

  // ==========================================================
  // conversion clock divider
  // ==========================================================
  logic [15:0] div_q, div_d;
  logic ck_q, ck_d;

  always_comb begin
    div_d = (div_q == HALF_M1) ? 16'h0000 : div_q + 16'h0001;
    ck_d = (div_q == HALF_M1) ? ~ck_q : ck_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
      ck_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ck_q <= ck_d;
    end
  end

  // ==========================================================
  // pin input filtering
  // ==========================================================
  logic [11:0] raw;
  logic [11:0] s1_q, s2_q, s3_q, dat_q, dat_d;
  logic b1_q, b2_q, b3_q, busy_n_q, busy_n_d;
  logic busy_q, busy_d;

  assign raw = {pins.upper_data_pins, pins.shared_low_data_pins};

  always_comb begin
    dat_d = sap_agree12(dat_q, s2_q, s3_q);
    busy_n_d = (b2_q & b3_q) | (busy_n_q & (b2_q ^ b3_q));
    busy_d = ~busy_n_d;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dat_q <= '0;
      b1_q <= 1'b1;
      b2_q <= 1'b1;
      b3_q <= 1'b1;
      busy_n_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dat_q <= dat_d;
      b1_q <= pins.conv_busy_n;
      b2_q <= b1_q;
      b3_q <= b2_q;
      busy_n_q <= busy_n_d;
      busy_q <= busy_d;
    end
  end

  // ==========================================================
  // access sequencer
  // ==========================================================
  sap_host_state_t st_q, st_d;
  logic [15:0] acq_q, acq_d;
  logic [15:0] gap_q, gap_d;
  logic [15:0] cnt_q, cnt_d;
  logic cs_n_q, cs_n_d;
  logic rd_n_q, rd_n_d;
  logic hb_q, hb_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [11:0] rdat_q, rdat_d;
  logic window;
  logic may_go;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cs_n_d = cs_n_q;
    rd_n_d = rd_n_q;
    hb_d = hb_q;
    rdy_d = rdy_q;
    rv_d = 1'b0;
    rdat_d = rdat_q;
    // acquisition time counts from the end of the last conversion
    acq_d = ~busy_n_q ? 16'h0000 :
            (acq_q == ACQ_MAX) ? acq_q : acq_q + 16'h0001;
    gap_d = ~rd_n_q ? 16'h0000 :
            (gap_q == GAP_MAX) ? gap_q : gap_q + 16'h0001;
    window = (div_q >= WIN_LO) && (div_q < WIN_HI);
    may_go = (gap_q == GAP_MAX) &&
             (hb_q || (busy_n_q && acq_q == ACQ_MAX && window));
    case (st_q)
      SAP_HOST_IDLE: begin
        if (cmd_valid && rdy_q) begin
          st_d = SAP_HOST_ALIGN;
          rdy_d = 1'b0;
          hb_d = cmd_high;
          cs_n_d = 1'b0;
        end
      end
      SAP_HOST_ALIGN: begin
        if (may_go) begin
          st_d = SAP_HOST_STROBE;
          rd_n_d = 1'b0;
          cnt_d = 16'h0000;
        end
      end
      SAP_HOST_STROBE: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == PULSE_MAX) begin
          st_d = SAP_HOST_IDLE;
          rd_n_d = 1'b1;
          cs_n_d = 1'b1;
          rdat_d = dat_q;
          rv_d = 1'b1;
          rdy_d = 1'b1;
        end
      end
      default: begin
        st_d = SAP_HOST_IDLE;
        rd_n_d = 1'b1;
        cs_n_d = 1'b1;
        rdy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= SAP_HOST_IDLE;
      acq_q <= ACQ_MAX;
      gap_q <= GAP_MAX;
      cnt_q <= 16'h0000;
      cs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      hb_q <= 1'b0;
      rdy_q <= 1'b1;
      rv_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      st_q <= st_d;
      acq_q <= acq_d;
      gap_q <= gap_d;
      cnt_q <= cnt_d;
      cs_n_q <= cs_n_d;
      rd_n_q <= rd_n_d;
      hb_q <= hb_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  assign pins.cs_n = cs_n_q;
  assign pins.rd_n = rd_n_q;
  assign pins.high_byte_select = hb_q;
  assign pins.clk_in = ck_q;
  assign cmd_ready = rdy_q;
  assign rsp_valid = rv_q;
  assign rsp_data = rdat_q;
  assign adc_busy = busy_q;

endmodule : sap_host
`default_nettype wire

/* File: dv/sap_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
module sap_properties
  import sap_pkg::*;
#(
  parameter int CLK_DIV = `SAP_CONV_CLK_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic clk_in,
  // device pins
  input wire logic clk_out,
  input wire logic conv_busy_n,
  input wire logic [7:0] upper_data_pins,
  input wire logic [3:0] shared_low_data_pins,
  input wire logic data_oe
);
  localparam int LEN_MIN = 12 * CLK_DIV - 1;
  localparam int LEN_MAX = 13 * CLK_DIV + 1;
  localparam int ACQ = `SAP_ACQ_CYC;
  localparam int RD_GAP = `SAP_RD_GAP_CYC;
  // ==========================================
  // helper counters
  logic start_req;
  logic [15:0] busy_cnt_q, busy_cnt_d;
  logic [9:0] idle_cnt_q, idle_cnt_d, rdhi_cnt_q, rdhi_cnt_d;
  assign start_req = !cs_n && !rd_n && !high_byte_select;
  always_comb begin
    busy_cnt_d = conv_busy_n ? 16'h0 : busy_cnt_q + 16'h1;
    idle_cnt_d = idle_cnt_q + {9'h0, idle_cnt_q != 10'h3FF};
    rdhi_cnt_d = rdhi_cnt_q + {9'h0, rdhi_cnt_q != 10'h3FF};
    if (!conv_busy_n) idle_cnt_d = 10'h0;
    if (!rd_n) rdhi_cnt_d = 10'h0;
  end
  // saturated at reset: the first start has no earlier conversion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 16'h0;
      idle_cnt_q <= 10'h3FF;
      rdhi_cnt_q <= 10'h3FF;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      idle_cnt_q <= idle_cnt_d;
      rdhi_cnt_q <= rdhi_cnt_d;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_OE_OFF: assert property ((cs_n || rd_n) [*8] |-> !data_oe)
    else $error("data pins driven without read");
  AST_OE_ON: assert property ((!cs_n && !rd_n) [*8] |-> data_oe)
    else $error("data pins not driven during read");
  AST_BUSY_CAUSE: assert property ($fell(conv_busy_n) |->
    $past(start_req, 3)) else $error("conversion without start");
  AST_START: assert property ($fell(rd_n) && start_req && conv_busy_n
    |-> ##[2:8] !conv_busy_n) else $error("start not taken");
  AST_HB_NO_START: assert property ($fell(rd_n) && !cs_n
    && high_byte_select && conv_busy_n |-> conv_busy_n [*8])
    else $error("byte read started a conversion");
  AST_BUSY_LEN: assert property ($rose(conv_busy_n) |->
    busy_cnt_q >= LEN_MIN && busy_cnt_q <= LEN_MAX)
    else $error("conversion length out of range");
  AST_CLK_INV: assert property ($stable(clk_in) [*8] |->
    clk_out == !clk_in) else $error("clock output not inverted");
  AST_HB_FORMAT: assert property ((data_oe && high_byte_select) [*8]
    |-> upper_data_pins[3:0] == 4'h0
    && shared_low_data_pins == upper_data_pins[7:4])
    else $error("byte read format wrong");
  AST_ACQ_GAP: assert property ($fell(rd_n) && start_req |->
    idle_cnt_q >= ACQ) else $error("acquisition gap too short");
  AST_RD_GAP: assert property ($fell(rd_n) |-> rdhi_cnt_q >= RD_GAP)
    else $error("read strobe gap too short");
  AST_HB_HOLD: assert property (!rd_n && !$past(rd_n) |->
    $stable(high_byte_select)) else $error("byte select moved");
  AST_CLK_GUARD: assert property ($fell(rd_n) && start_req |->
    clk_in == $past(clk_in, 10) ##9 clk_in == $past(clk_in, 10))
    else $error("start too near a clock edge");
  cover property ($fell(conv_busy_n));
  cover property ($rose(conv_busy_n));
  cover property ((data_oe && high_byte_select) [*8]);
endmodule : sap_properties
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import sap_pkg::*;
;
  localparam int DIV = 48;
  typedef struct packed {
    logic high;
    logic [11:0] level;
    logic [11:0] rsp;
    logic [11:0] lat;
  } sap_row_t;
  logic sys_clk, rst, cmd_valid, cmd_high, cmd_ready, rsp_valid, adc_busy;
  logic result_strobe, converting, r2_strobe, r2_conv;
  logic [11:0] level, rsp_data, result_word, r2_word;
  int num_errors = 0, checked = 0, cyc = 0, dv = 0, n, t0;
  // word reads return the previous result, byte reads the top nibble twice
  sap_row_t rows [7] = '{'{1'h0, 12'hA5C, 12'h000, 12'hA5C},
    '{1'h1, 12'h000, 12'hA0A, 12'hA5C}, '{1'h0, 12'h3F1, 12'hA5C, 12'h3F1},
    '{1'h1, 12'h000, 12'h303, 12'h3F1}, '{1'h0, 12'hFFF, 12'h3F1, 12'hFFF},
    '{1'h1, 12'h000, 12'hF0F, 12'hFFF}, '{1'h0, 12'h000, 12'hFFF, 12'h000}};
  sap_if link ();
  sap_if side ();
  sap_device sap_device_i (.sys_clk(sys_clk), .rst(rst), .pins(link.device),
    .analog_level(level), .result_word(result_word),
    .result_strobe(result_strobe), .converting(converting));
  // second device faces the bench so refusals can be provoked
  sap_device sap_device_i2 (.sys_clk(sys_clk), .rst(rst),
    .pins(side.device), .analog_level(level), .result_word(r2_word),
    .result_strobe(r2_strobe), .converting(r2_conv));
  sap_host #(.CLK_DIV(DIV)) sap_host_i (.sys_clk(sys_clk), .rst(rst),
    .pins(link.host), .cmd_valid(cmd_valid), .cmd_high(cmd_high),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .adc_busy(adc_busy));
  sap_properties #(.CLK_DIV(DIV)) sap_properties_i (.sys_clk(sys_clk),
    .rst(rst), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .high_byte_select(link.high_byte_select), .clk_in(link.clk_in),
    .clk_out(link.clk_out), .conv_busy_n(link.conv_busy_n),
    .upper_data_pins(link.upper_data_pins),
    .shared_low_data_pins(link.shared_low_data_pins),
    .data_oe(link.data_oe));
  // ==========================================
  // clock, side conversion clock, timeout
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    dv <= (dv == DIV / 2 - 1) ? 0 : dv + 1;
    if (dv == DIV / 2 - 1) side.clk_in <= ~side.clk_in;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================
  // tasks
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic run_row(sap_row_t r);
    int strobes;
    strobes = 0;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    level = r.level;
    cmd_high = r.high;
    cmd_valid = 1'h1;
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    check("rsp_data", rsp_data, r.rsp);
    check("converting", 12'(converting), 12'(!r.high));
    check("adc_busy", 12'(adc_busy), 12'(!r.high));
    n = 0;
    while (converting !== 1'h0 && n < 2000) begin
      @(negedge sys_clk);
      strobes += int'(result_strobe);
      n++;
    end
    check("result_word", result_word, r.lat);
    check("strobes", 12'(strobes), 12'(!r.high));
  endtask : run_row
  task automatic side_pins(logic cs, logic rd, logic hb, int cycles);
    side.cs_n = cs;
    side.rd_n = rd;
    side.high_byte_select = hb;
    repeat (cycles) @(negedge sys_clk);
  endtask : side_pins
  // ==========================================
  // main sequence
  initial begin
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_high = 1'h0;
    level = 12'h000;
    side.clk_in = 1'h0;
    side_pins(1'h1, 1'h1, 1'h0, 0);
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    check("busy_reset", 12'(link.conv_busy_n), 12'h001);
    check("oe_reset", 12'(link.data_oe), 12'h000);
    foreach (rows[i]) run_row(rows[i]);
    level = 12'h9C3;
    side_pins(1'h1, 1'h0, 1'h0, 40);
    check("side_busy", 12'(side.conv_busy_n), 12'h001);
    check("side_oe", 12'(side.data_oe), 12'h000);
    side_pins(1'h0, 1'h0, 1'h1, 40);
    check("side_busy", 12'(side.conv_busy_n), 12'h001);
    check("side_oe", 12'(side.data_oe), 12'h001);
    side_pins(1'h1, 1'h1, 1'h0, 60);
    t0 = cyc;
    side_pins(1'h0, 1'h0, 1'h0, 20);
    check("side_busy", 12'(side.conv_busy_n), 12'h000);
    check("side_conv", 12'(r2_conv), 12'h001);
    // second strobe mid conversion must not restart it
    side_pins(1'h1, 1'h1, 1'h0, 60);
    side_pins(1'h0, 1'h0, 1'h0, 20);
    side_pins(1'h1, 1'h1, 1'h0, 1);
    while (side.conv_busy_n !== 1'h1 && cyc - t0 < 2000) @(negedge sys_clk);
    check("side_len", 12'(cyc - t0 >= 12 * DIV && cyc - t0 <= 13 * DIV + 8),
      12'h001);
    check("side_strobe", 12'(r2_strobe), 12'h001);
    check("side_word", r2_word, 12'h9C3);
    @(negedge sys_clk);
    check("side_data", {side.upper_data_pins, side.shared_low_data_pins},
      12'h9C3);
    side_pins(1'h1, 1'h1, 1'h0, 60);
    side_pins(1'h0, 1'h0, 1'h1, 30);
    check("side_hb", {side.upper_data_pins, side.shared_low_data_pins},
      12'h909);
    while (dv != 12) @(negedge sys_clk);
    check("side_clk", 12'(side.clk_out ^ side.clk_in), 12'h001);
    side_pins(1'h1, 1'h1, 1'h0, 300);
    side_pins(1'h0, 1'h0, 1'h0, 30);
    check("side_wd", {side.upper_data_pins, side.shared_low_data_pins},
      12'h9C3);
    side_pins(1'h1, 1'h1, 1'h0, 20);
    check("side_oe", 12'(side.data_oe), 12'h000);
    results();
  end
endmodule : testbench
`default_nettype wire
